// ==== pkg/trng_pkg.sv ====
// Constants for the random seed generator: register map, fields, reset values.
// Assumes a 32-bit APB slave on pclk with registers at word-aligned offsets.
//
// Notes on behaviour
// - Writing one to the generator-enable bit enables the generator.
// - The interrupt-enable bit and the mask bit together decide whether the interrupt output is driven.
// - Writing one to the generation-start bit begins producing a seed.
// - The interrupt rises when a seed is available; four seed reads follow.
// - Clearing enable disables the generator; clearing start stops generation.
`default_nettype none
package trng_pkg;

  localparam logic [7:0]  ctrl0_off    = 8'h00;
  localparam logic [7:0]  ctrl1_off    = 8'h04;
  localparam logic [7:0]  seed_off     = 8'h08;
  localparam logic [7:0]  status_off   = 8'h0c;
  localparam logic [7:0]  mask_off     = 8'h10;
  localparam logic [7:0]  modstop_off  = 8'h14;

  localparam int          enable_bit   = 0;
  localparam int          start_bit    = 1;
  localparam int          ready_bit    = 2;
  localparam int          irqen_bit    = 0;
  localparam int          seed_ev_bit  = 0;
  localparam int          modstop_bit  = 0;

  localparam logic        modstop_rst  = 1'b1;
  localparam logic [2:0]  stop_wait_cycles = 3'h6;

  localparam int          seed_words   = 4;
  localparam int          word_bits    = 32;
  localparam logic [31:0] lfsr_seed    = 32'h0000_0001;
  localparam logic [31:0] lfsr_taps    = 32'h8020_0003;

  typedef enum logic [2:0] {
    gen_idle    = 3'b001,
    gen_collect = 3'b010,
    gen_ready   = 3'b100
  } gen_state_e;

endpackage
`default_nettype wire

// ==== src/true_random_seed_generator.sv ====
// APB register slave and seed collector of the random seed generator.
// Assumes one clock pclk, an asynchronous entropy pin, and a
// level interrupt consumed by an interrupt controller on pclk.
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`default_nettype none
module true_random_seed_generator
  import trng_pkg::*;
#(
  parameter int seed_count = seed_words
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        entropy_in,
  output logic             irq
);

  localparam int seed_bits = seed_count * word_bits;
  localparam int cnt_w     = $clog2(seed_bits + 1);
  localparam int idx_w     = $clog2(seed_count + 1);
  localparam logic [cnt_w-1:0] full_cnt = cnt_w'(seed_bits);
  localparam logic [idx_w-1:0] last_idx = idx_w'(seed_count - 1);

  typedef struct packed {
    logic                 sync1;
    logic                 sync2;
    logic                 sync3;
    logic                 ent_bit;
    logic                 module_stop;
    logic [2:0]           wake_cnt;
    logic                 generator_enable;
    logic                 generation_start;
    logic                 seed_ready_flag;
    logic                 rng_irq_enable;
    logic                 status;
    logic                 mask;
    gen_state_e           state;
    logic [cnt_w-1:0]     bit_cnt;
    logic [idx_w-1:0]     read_idx;
    logic [31:0]          lfsr;
    logic [seed_bits-1:0] seed;
    logic [31:0]          rdata;
    logic                 ready;
    logic                 slverr;
    logic                 irq;
  } state_s;

  state_s cur_reg;
  state_s cur_next;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == ctrl0_off) || (a == ctrl1_off) || (a == seed_off) ||
             (a == status_off) || (a == mask_off) || (a == modstop_off);
  endfunction

  function automatic logic [31:0] lfsr_step(input logic [31:0] v);
    lfsr_step = {v[30:0], ^(v & lfsr_taps)};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic setup;
  logic access;
  logic wr;
  logic rd;
  logic awake;
  logic lane0;
  logic seed_event;

  assign setup  = psel && !penable;
  assign access = psel && penable && cur_reg.ready;
  assign wr     = access && pwrite && !cur_reg.slverr;
  assign rd     = access && !pwrite && !cur_reg.slverr;
  assign lane0  = pstrb[0];
  // Enable, start and interrupt-enable settings are ignored until the clock has settled; module stop and mask are not
  assign awake  = !cur_reg.module_stop && (cur_reg.wake_cnt == stop_wait_cycles);

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    cur_next = cur_reg;
    seed_event = 1'b0;

    // Three-stage pin synchroniser; a change counts when stages two and three agree
    cur_next.sync1 = entropy_in;
    cur_next.sync2 = cur_reg.sync1;
    cur_next.sync3 = cur_reg.sync2;
    if (cur_reg.sync2 == cur_reg.sync3) begin
      cur_next.ent_bit = cur_reg.sync3;
    end

    // Whitening keeps a stuck pin from yielding an all-equal seed
    cur_next.lfsr = lfsr_step(cur_reg.lfsr);

    if (cur_reg.module_stop) begin
      cur_next.wake_cnt = 3'h0;
    end else if (cur_reg.wake_cnt != stop_wait_cycles) begin
      cur_next.wake_cnt = cur_reg.wake_cnt + 3'h1;
    end

    // Register writes
    if (wr && lane0) begin
      case (paddr)
        modstop_off: begin
          cur_next.module_stop = pwdata[modstop_bit];
        end
        ctrl0_off: begin
          if (awake) begin
            cur_next.generator_enable = pwdata[enable_bit];
            cur_next.generation_start = pwdata[start_bit];
          end
        end
        ctrl1_off: begin
          if (awake) begin
            cur_next.rng_irq_enable = pwdata[irqen_bit];
          end
        end
        mask_off: begin
          cur_next.mask = pwdata[seed_ev_bit];
        end
        default: begin
        end
      endcase
    end

    // Seed collection
    case (cur_reg.state)
      gen_idle: begin
        cur_next.seed_ready_flag = 1'b0;
        cur_next.bit_cnt = '0;
        cur_next.read_idx = '0;
        if (cur_reg.generator_enable && cur_reg.generation_start && awake) begin
          cur_next.state = gen_collect;
        end
      end
      gen_collect: begin
        cur_next.seed = {cur_reg.seed[seed_bits-2:0],
                         cur_reg.ent_bit ^ cur_reg.lfsr[0]};
        cur_next.bit_cnt = cur_reg.bit_cnt + cnt_w'(1);
        if (cur_reg.bit_cnt == full_cnt - cnt_w'(1)) begin
          cur_next.state = gen_ready;
          cur_next.seed_ready_flag = 1'b1;
          seed_event = 1'b1;
        end
      end
      gen_ready: begin
        if (rd && paddr == seed_off) begin
          cur_next.read_idx = cur_reg.read_idx + idx_w'(1);
          if (cur_reg.read_idx == last_idx) begin
            cur_next.seed_ready_flag = 1'b0;
            cur_next.read_idx = '0;
            cur_next.bit_cnt = '0;
            cur_next.state = gen_idle;
          end
        end
      end
      default: begin
        cur_next.state = gen_idle;
      end
    endcase

    // Disable or stop aborts any seed in progress
    if (!cur_next.generator_enable || !cur_next.generation_start ||
        cur_next.module_stop) begin
      cur_next.state = gen_idle;
      cur_next.seed_ready_flag = 1'b0;
    end

    // Sticky event: a new event wins over a same-cycle write-one-to-clear
    if (wr && lane0 && paddr == status_off && pwdata[seed_ev_bit]) begin
      cur_next.status = 1'b0;
    end
    if (seed_event) begin
      cur_next.status = 1'b1;
    end

    cur_next.irq = cur_next.rng_irq_enable && cur_next.status && cur_next.mask;

    // Answer in the cycle after setup; read data sampled at setup
    cur_next.ready = setup;
    cur_next.slverr = setup && !mapped(paddr);
    cur_next.rdata = 32'h0000_0000;
    if (setup && !pwrite) begin
      case (paddr)
        ctrl0_off: begin
          cur_next.rdata[enable_bit] = cur_reg.generator_enable;
          cur_next.rdata[start_bit] = cur_reg.generation_start;
          cur_next.rdata[ready_bit] = cur_reg.seed_ready_flag;
        end
        ctrl1_off: begin
          cur_next.rdata[irqen_bit] = cur_reg.rng_irq_enable;
        end
        seed_off: begin
          // Words come out most significant first; zero unless a seed is ready
          if (cur_reg.seed_ready_flag) begin
            cur_next.rdata = cur_reg.seed[(seed_count - 1 -
                             int'(cur_reg.read_idx)) * word_bits +: word_bits];
          end
        end
        status_off: begin
          cur_next.rdata[seed_ev_bit] = cur_reg.status;
        end
        mask_off: begin
          cur_next.rdata[seed_ev_bit] = cur_reg.mask;
        end
        modstop_off: begin
          cur_next.rdata[modstop_bit] = cur_reg.module_stop;
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_reg <= '{
        sync1: 1'b0,
        sync2: 1'b0,
        sync3: 1'b0,
        ent_bit: 1'b0,
        module_stop: modstop_rst,
        wake_cnt: 3'h0,
        generator_enable: 1'b0,
        generation_start: 1'b0,
        seed_ready_flag: 1'b0,
        rng_irq_enable: 1'b0,
        status: 1'b0,
        mask: 1'b0,
        state: gen_idle,
        bit_cnt: '0,
        read_idx: '0,
        lfsr: lfsr_seed,
        seed: '0,
        rdata: 32'h0000_0000,
        ready: 1'b0,
        slverr: 1'b0,
        irq: 1'b0
      };
    end else if (clk_en) begin
      cur_reg <= cur_next;
    end
  end

  assign prdata  = cur_reg.rdata;
  assign pready  = cur_reg.ready;
  assign pslverr = cur_reg.slverr;
  assign irq     = cur_reg.irq;

endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking register-level bench for the random seed generator.
// Assumes the package constants; APB answers are waited for, not counted.
`default_nettype none
module testbench
  import trng_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        pclk, presetn, clk_en, psel, penable, pwrite;
  logic        entropy_in = 1'b0;
  logic [3:0]  pstrb;
  logic        pready, pslverr, irq, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          n_mismatch, samples_checked;

  true_random_seed_generator u_dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .entropy_in, .irq);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Entered just after a rising edge; holds the request until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so no signal is driven twice in one time step
    @(posedge pclk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic get_seed();
    repeat (seed_words) begin
      apb(1'b0, seed_off, 32'h0);
      chk(32'(er), 32'h0);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) entropy_in <= ~entropy_in ^ paddr[3];
  initial begin
    repeat (4000) @(posedge pclk);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    {presetn, clk_en, psel, penable, pwrite} = 5'h08; // Reset asserted, clock enabled, bus idle
    pstrb = 4'hf;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(32'(irq), 32'h0);
    rdc(modstop_off, 32'h1);
    apb(1'b1, ctrl0_off, 32'h3);
    rdc(ctrl0_off, 32'h0);
    apb(1'b1, modstop_off, 32'h0);
    // Too soon after release, so ignored
    apb(1'b1, ctrl0_off, 32'h1);
    rdc(ctrl0_off, 32'h0);
    repeat (stop_wait_cycles) @(posedge pclk);
    apb(1'b1, ctrl0_off, 32'h1);
    rdc(ctrl0_off, 32'h1);
    apb(1'b1, ctrl1_off, 32'h1);
    apb(1'b1, mask_off, 32'h1);
    apb(1'b1, ctrl0_off, 32'h3);
    rdc(ctrl0_off, 32'h3);
    for (int i = 0; i < 300 && irq !== 1'b1; i++) @(posedge pclk);
    chk(32'(irq), 32'h1);
    rdc(ctrl0_off, 32'h7);
    get_seed();
    rdc(ctrl0_off, 32'h3);
    rdc(seed_off, 32'h0);
    apb(1'b1, status_off, 32'h1);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0);
    apb(1'b1, ctrl1_off, 32'h0);
    rd = 32'h0;
    for (int i = 0; i < 100 && rd[2] !== 1'b1; i++) apb(1'b0, ctrl0_off, 32'h0);
    chk(rd, 32'h7);
    chk(32'(irq), 32'h0);
    get_seed();
    clk_en <= 1'b0;
    repeat (3) @(posedge pclk);
    clk_en <= 1'b1;
    // Clear the old event first, so a seed made while disabled would show
    apb(1'b1, status_off, 32'h1);
    apb(1'b1, ctrl0_off, 32'h0);
    repeat (200) @(posedge pclk);
    rdc(ctrl0_off, 32'h0);
    rdc(status_off, 32'h0);
    // Byte lane 0 off, so the write must not land
    pstrb <= 4'h0;
    apb(1'b1, mask_off, 32'h0);
    pstrb <= 4'hf;
    rdc(mask_off, 32'h1);
    apb(1'b1, modstop_off, 32'h1);
    rdc(modstop_off, 32'h1);
    apb(1'b0, 8'h18, 32'h0);
    chk(32'(er), 32'h1);
    chk(rd, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire

// ==== tb/trng_monitor.sv ====
// Port-level checks for the random seed generator.
// Assumes the generator's top module; attached by the bind at the foot.
`default_nettype none
module trng_monitor
  import trng_pkg::*;
#(
  parameter int seed_count = seed_words
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_SETUP_ANSWER: assert property (psel && !penable && clk_en |=> pready)
    else $error("no answer after setup");
  AST_READY_PULSE: assert property (pready && clk_en |=> !pready)
    else $error("answer longer than one cycle");
  AST_IDLE_QUIET: assert property (!psel && clk_en |=> !pready)
    else $error("answer without request");
  AST_ERR_PAIR: assert property (pslverr |-> pready)
    else $error("error outside answer");
  AST_UNMAPPED: assert property (psel && penable && paddr > 8'h14 |-> pslverr && prdata == 0)
    else $error("unmapped access not refused");
  AST_MAPPED_OK: assert property (psel && penable && paddr <= 8'h14 && paddr[1:0] == 2'h0
    |-> !pslverr)
    else $error("mapped access refused");
  AST_IRQ_STICKY: assert property (irq && !(psel && penable && pwrite) |=> irq)
    else $error("interrupt dropped without write");
  AST_FREEZE: assert property (!clk_en |=> $stable(irq) && $stable(pready))
    else $error("outputs moved while clock disabled");
endmodule
bind true_random_seed_generator trng_monitor #(.seed_count(seed_count)) u_mon (.pclk, .presetn,
  .clk_en, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .irq);
`default_nettype wire
